/* File: hw/crx_pkg.sv */
package crx_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAME_START_DETECT = 8'h34;
  localparam logic [7:0] IDX_RECEIVE_CONTROL    = 8'h35;
  localparam logic [7:0] IDX_RECEIVE_BLANKING   = 8'h36;
  localparam logic [7:0] IDX_DECODER_THRESHOLD  = 8'h37;
  localparam logic [7:0] IDX_RECEIVER_INPUT_SEL = 8'h38;
  localparam logic [7:0] IDX_RX_STATUS          = 8'h40;

  // frame_start_detect fields
  localparam int FSD_FRAME_EN   = 5;
  localparam int FSD_FRAME_SEEN = 4;
  localparam int FSD_SUBCARRIER_EVENT_EN    = 2;
  localparam int FSD_SUBC_SEEN  = 1;
  localparam int FSD_SUBC_LIVE  = 0;
  localparam logic [7:0] FSD_WMASK = 8'h24;

  // receive_control fields
  localparam int RCT_PARTIAL  = 7;
  localparam int RCT_MULTI    = 6;
  localparam int RCT_SUPPRESS = 3;
  localparam logic [7:0] RCT_WMASK = 8'hCF;

  // receiver_input_select writable bits
  localparam logic [7:0] RIS_WMASK = 8'hF3;

  // reset values
  localparam logic [7:0] RST_FSD = 8'h00;
  localparam logic [7:0] RST_RCT = 8'h04;
  localparam logic [7:0] RST_BLK = 8'h00;
  localparam logic [7:0] RST_THR = 8'h00;
  localparam logic [7:0] RST_RIS = 8'h00;

  // baud rate codes
  localparam logic [2:0] BAUD_106 = 3'h4;
  localparam logic [2:0] BAUD_212 = 3'h5;
  localparam logic [2:0] BAUD_424 = 3'h6;
  localparam logic [2:0] BAUD_847 = 3'h7;

  // timing at 10 MHz: 16 carrier periods of 13.56 MHz ~ 1180 ns
  localparam int CLK_PERIOD_NS      = 100;
  localparam int CARRIER16_NS       = 1180;
  localparam int CARRIER16_CYC      = (CARRIER16_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  // half bit period at 106 kBd ~ 4720 ns
  localparam int HALF_BIT_106_NS    = 4720;
  localparam int HALF_BIT_106_CYC   = (HALF_BIT_106_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int SUPPRESS_BYTES     = 3;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } crx_byte_t;

  typedef struct packed {
    logic       frame_start;
    logic       subc_live;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       frame_end;
    logic       last_partial;
    logic       error;
    logic       collision;
  } crx_rx_evt_t;

  typedef struct packed {
    logic [1:0] input_sel;
    logic [1:0] coll_level;
    logic       converter_mode;
  } crx_front_cfg_t;

endpackage

/* File: hw/crx_blanking.sv */
`timescale 1ns/1ps
`default_nettype none
module crx_blanking
  import crx_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       tx_done_i,
  input  wire logic [6:0] count_i,
  input  wire logic       unit_sel_i,
  input  wire logic [2:0] baud_i,
  // status
  output logic            blank_o
);

  logic [7:0] unit_cyc;
  logic [7:0] unit_q;
  logic [6:0] left_q;

  // faster rates shorten the half bit period by powers of two
  always_comb
  begin
    unit_cyc = 8'(CARRIER16_CYC);
    if (unit_sel_i)
    begin
      unique case (baud_i)
        BAUD_212: unit_cyc = 8'(HALF_BIT_106_CYC / 2);
        BAUD_424: unit_cyc = 8'(HALF_BIT_106_CYC / 4);
        BAUD_847: unit_cyc = 8'(HALF_BIT_106_CYC / 8);
        default:  unit_cyc = 8'(HALF_BIT_106_CYC);
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      left_q <= 7'h00;
      unit_q <= 8'h00;
    end
    else if (tx_done_i)
    begin
      left_q <= count_i; // R15
      unit_q <= unit_cyc; // R14
    end
    else if (left_q != 7'h00)
    begin
      if (unit_q <= 8'h01)
      begin
        left_q <= left_q - 7'h01;
        unit_q <= unit_cyc;
      end
      else
        unit_q <= unit_q - 8'h01;
    end
  end

  assign blank_o = (left_q != 7'h00);

endmodule
`default_nettype wire

/* File: hw/crx_framer.sv */
`timescale 1ns/1ps
`default_nettype none
module crx_framer
  import crx_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // settings
  input  wire logic        partial_byte_allow_i,
  input  wire logic        multi_frame_receive_i,
  input  wire logic        disturbance_suppress_i,
  input  wire logic        checksum_en_i,
  input  wire logic [7:0]  error_reg_i,
  // receive events
  input  wire crx_rx_evt_t evt_i,
  input  wire logic        active_i,
  // fifo side
  output crx_byte_t        fifo_o,
  output logic             fifo_flush_o,
  output logic             rx_done_o,
  output logic             rx_stop_o
);

  logic [1:0] cnt_q;
  logic       err_q;
  logic       early;
  logic       bad;
  logic       take;
  logic       emd_case;

  assign early = (cnt_q < 2'(SUPPRESS_BYTES));
  // collision counts as error only in suppression
  assign bad = evt_i.error | (disturbance_suppress_i & evt_i.collision); // R10
  assign take = evt_i.byte_valid & active_i
                & (!evt_i.last_partial | partial_byte_allow_i
                   | !checksum_en_i); // R6

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cnt_q <= 2'h0;
    else if (evt_i.frame_start || evt_i.frame_end)
      cnt_q <= 2'h0;
    else if (take && early)
      cnt_q <= cnt_q + 2'h1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      err_q <= 1'b0;
    else if (evt_i.frame_start)
      err_q <= 1'b0;
    else if (emd_case)
      err_q <= 1'b1; // R11
  end

  // short frame or early error is disturbance
  assign emd_case = disturbance_suppress_i & active_i
                    & ((bad & early) | (evt_i.frame_end & early)); // R9 R10

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fifo_o       <= '0;
      fifo_flush_o <= 1'b0;
      rx_done_o    <= 1'b0;
      rx_stop_o    <= 1'b0;
    end
    else
    begin
      fifo_o.valid <= 1'b0;
      fifo_o.data  <= fifo_o.data;
      fifo_flush_o <= emd_case; // R9
      rx_done_o    <= 1'b0;
      rx_stop_o    <= 1'b0;
      if (take && !emd_case)
      begin
        fifo_o.valid <= 1'b1;
        fifo_o.data  <= evt_i.byte_data;
      end
      // a disturbed frame never completes, even when it runs on
      if (evt_i.frame_end && active_i && !emd_case && !err_q)
      begin
        rx_done_o <= 1'b1; // R11
        rx_stop_o <= !multi_frame_receive_i; // R7
        if (multi_frame_receive_i)
        begin
          fifo_o.valid <= 1'b1; // R8
          fifo_o.data  <= error_reg_i;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/crx_top.sv */
// Functional notes
// (R1) frame-start enable bit 5 raises frame-start interrupt on start-of-frame
// (R2) sticky frame-start-seen bit 4 set on start-of-frame until cleared
// (R3) subcarrier enable bit 2 raises the same interrupt on subcarrier
// (R4) sticky subcarrier-seen bit 1 set on subcarrier detection
// (R5) read-only bit 0 shows live subcarrier presence
// (R6) partial-byte bit 7 writes incomplete last byte despite checksum
// (R7) multi-frame bit 6 keeps receiving after each frame
// (R8) multi-frame appends copy of error register after each stream
// (R9) suppression bit 3 discards early-error bytes and resets FIFO
// (R10) collisions and frames under three bytes count as disturbance; code counts a collision only within the first three bytes
// (R11) disturbance cases never set receive-complete flag
// (R12) host waits for three bytes before reading under forced checksum
// (R13) baud field codes 4h..7h select 106..847 kBd, others reserved
// (R14) blanking unit bit selects 16 carrier periods or half bit
// (R15) after transmit, input ignored for seven-bit blanking count; code gates only the framer, not bits 4 and 1 or the irq
// (R16) bits 7..4 set decoder minimum level
// (R17) bits 3..0 set phase detector minimum level
// (R18) input select: idle, analog, envelope, generic serial
// (R19) collision level codes 0h..2h thresholds, 3h disables
// (R20) converter mode bit: normal or low-power card detection
// (R21) writing zero clears sticky flag unless detection same cycle
`timescale 1ns/1ps
`default_nettype none
module crx_top
  import crx_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive path events
  input  wire logic        frame_start_i,
  input  wire logic        subcarrier_pin_i,
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_data_i,
  input  wire logic        frame_end_i,
  input  wire logic        last_partial_i,
  input  wire logic        rx_error_i,
  input  wire logic        collision_i,
  input  wire logic        tx_done_i,
  input  wire logic        checksum_en_i,
  input  wire logic [7:0]  error_reg_i,
  // fifo and status outputs
  output crx_byte_t        fifo_o,
  output logic             fifo_flush_o,
  output logic             rx_done_o,
  output logic             rx_stop_o,
  output logic             frame_start_irq_o,
  output logic             rx_blank_o,
  // settings to datapath
  output logic [2:0]       baud_sel_o,
  output logic             baud_valid_o,
  output logic [3:0]       decoder_min_level_o,
  output logic [3:0]       phase_min_level_o,
  output crx_front_cfg_t   front_cfg_o,
  output logic             collision_detect_en_o
);

  // registers
  logic [7:0] fsd_q;
  logic [7:0] rct_q;
  logic [7:0] blk_q;
  logic [7:0] thr_q;
  logic [7:0] ris_q;

  // subcarrier pin is asynchronous: three stages
  logic [2:0] subc_sync_q;
  logic       subc_live_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      subc_sync_q <= 3'h0;
    else
      subc_sync_q <= {subc_sync_q[1:0], subcarrier_pin_i};
  end

  // change accepted only when stages two and three agree
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      subc_live_q <= 1'b0;
    else if (subc_sync_q[1] == subc_sync_q[2])
      subc_live_q <= subc_sync_q[2];
  end

  logic subc_rise;
  logic subc_prev_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      subc_prev_q <= 1'b0;
    else
      subc_prev_q <= subc_live_q;
  end
  assign subc_rise = subc_live_q & !subc_prev_q;

  // apb decode; slave answers one cycle into the access phase (one wait state)
  logic       wr_en;
  logic       rd_en;
  logic [9:0] word;
  logic       hit;
  logic [7:0] rmux;

  assign word  = paddr[11:2];
  assign wr_en = psel & penable & pwrite & !pready;
  assign rd_en = psel & penable & !pwrite & !pready;

  always_comb
  begin
    hit  = 1'b1;
    rmux = 8'h00;
    unique case (word)
      10'(IDX_FRAME_START_DETECT): rmux = {fsd_q[7:1], subc_live_q}; // R5
      10'(IDX_RECEIVE_CONTROL):    rmux = rct_q;
      10'(IDX_RECEIVE_BLANKING):   rmux = blk_q;
      10'(IDX_DECODER_THRESHOLD):  rmux = thr_q;
      10'(IDX_RECEIVER_INPUT_SEL): rmux = ris_q;
      10'(IDX_RX_STATUS):          rmux = {5'h00, rx_blank_o, rx_stop_o,
                                           frame_start_irq_o};
      default:                     hit  = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0)
    begin
      hit  = 1'b0;
      rmux = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & !pready;
      pslverr <= psel & penable & !pready & !hit;
      if (rd_en)
        prdata <= {24'h00_0000, rmux};
      else if (!(psel & penable))
        prdata <= 32'h0000_0000;
    end
  end

  logic wr_fsd;
  assign wr_fsd = wr_en & hit & (word == 10'(IDX_FRAME_START_DETECT));

  // sticky flags: detection wins over software clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fsd_q <= RST_FSD;
    else
    begin
      if (wr_fsd)
      begin
        fsd_q[FSD_FRAME_EN] <= pwdata[FSD_FRAME_EN];
        fsd_q[FSD_SUBCARRIER_EVENT_EN]  <= pwdata[FSD_SUBCARRIER_EVENT_EN];
        if (!pwdata[FSD_FRAME_SEEN])
          fsd_q[FSD_FRAME_SEEN] <= 1'b0; // R21
        if (!pwdata[FSD_SUBC_SEEN])
          fsd_q[FSD_SUBC_SEEN] <= 1'b0; // R21
      end
      if (frame_start_i)
        fsd_q[FSD_FRAME_SEEN] <= 1'b1; // R2 R21
      if (subc_rise)
        fsd_q[FSD_SUBC_SEEN] <= 1'b1; // R4 R21
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rct_q <= RST_RCT;
      blk_q <= RST_BLK;
      thr_q <= RST_THR;
      ris_q <= RST_RIS;
    end
    else if (wr_en && hit)
    begin
      unique case (word)
        10'(IDX_RECEIVE_CONTROL):    rct_q <= pwdata[7:0] & RCT_WMASK;
        10'(IDX_RECEIVE_BLANKING):   blk_q <= pwdata[7:0];
        10'(IDX_DECODER_THRESHOLD):  thr_q <= pwdata[7:0];
        10'(IDX_RECEIVER_INPUT_SEL): ris_q <= pwdata[7:0] & RIS_WMASK;
        default:                     ;
      endcase
    end
  end

  // interrupt: either enabled detection event
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      frame_start_irq_o <= 1'b0;
    else
      frame_start_irq_o <= (fsd_q[FSD_FRAME_EN] & frame_start_i) // R1
                           | (fsd_q[FSD_SUBCARRIER_EVENT_EN] & subc_rise); // R3
  end

  // settings out, all registered
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      baud_sel_o            <= 3'h0;
      baud_valid_o          <= 1'b0;
      decoder_min_level_o   <= 4'h0;
      phase_min_level_o     <= 4'h0;
      front_cfg_o           <= '0;
      collision_detect_en_o <= 1'b0;
    end
    else
    begin
      baud_sel_o            <= rct_q[2:0];
      baud_valid_o          <= rct_q[2]; // R13
      decoder_min_level_o   <= thr_q[7:4]; // R16
      phase_min_level_o     <= thr_q[3:0]; // R17
      front_cfg_o.input_sel <= ris_q[5:4]; // R18
      front_cfg_o.coll_level     <= ris_q[1:0]; // R19
      front_cfg_o.converter_mode <= ris_q[6]; // R20
      collision_detect_en_o <= (ris_q[1:0] != 2'h3); // R19
    end
  end

  // blanking and framing
  logic        blank;
  crx_rx_evt_t evt;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rx_blank_o <= 1'b0;
    else
      rx_blank_o <= blank;
  end

  always_comb
  begin
    evt = '0;
    evt.frame_start  = frame_start_i;
    evt.subc_live    = subc_live_q;
    evt.byte_valid   = byte_valid_i;
    evt.byte_data    = byte_data_i;
    evt.frame_end    = frame_end_i;
    evt.last_partial = last_partial_i;
    evt.error        = rx_error_i;
    evt.collision    = collision_i & (ris_q[1:0] != 2'h3);
  end

  crx_blanking u_blank (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .tx_done_i  (tx_done_i),
    .count_i    (blk_q[6:0]),
    .unit_sel_i (blk_q[7]),
    .baud_i     (rct_q[2:0]),
    .blank_o    (blank)
  );

  // framer input during blanking is ignored; the detect flags and the irq still see it
  crx_framer u_frame (
    .clk_i                  (clk_i),
    .reset_n_i              (reset_n_i),
    .partial_byte_allow_i   (rct_q[RCT_PARTIAL]),
    .multi_frame_receive_i  (rct_q[RCT_MULTI]),
    .disturbance_suppress_i (rct_q[RCT_SUPPRESS]),
    .checksum_en_i          (checksum_en_i),
    .error_reg_i            (error_reg_i),
    .evt_i                  (evt),
    .active_i               (!blank), // R15
    .fifo_o                 (fifo_o),
    .fifo_flush_o           (fifo_flush_o),
    .rx_done_o              (rx_done_o),
    .rx_stop_o              (rx_stop_o)
  );

endmodule
`default_nettype wire

/* File: testbench/crx_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module crx_asserts
  import crx_pkg::*;
(
  // clock and reset
  input wire logic           clk_i,
  input wire logic           reset_n_i,
  // apb
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // events and settings
  input wire logic           frame_start_i,
  input wire logic           frame_start_irq_o,
  input wire logic           fifo_flush_o,
  input wire logic           rx_done_o,
  input wire logic [2:0]     baud_sel_o,
  input wire logic           baud_valid_o,
  input wire logic [3:0]     decoder_min_level_o,
  input wire logic [3:0]     phase_min_level_o,
  input wire crx_front_cfg_t front_cfg_o,
  input wire logic           collision_detect_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic        wr;
  logic        fen_q;
  logic [31:0] wd_q;
  assign wr = psel && penable && pready && pwrite;
  // shadow enable lags the real bit, so frames must not race a write
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      fen_q <= 1'b0;
    else if (wr && paddr == 12'h0D0)
      fen_q <= pwdata[5];
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      wd_q <= 32'h0;
    else
      wd_q <= pwdata;
  pready_wait_a:
    assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  bad_addr_a:
    assert property (psel && penable && pready && paddr[1:0] != 2'h0
      |-> pslverr) else $error("no slave error");
  frame_irq_a:
    assert property (fen_q && frame_start_i |-> ##[1:2] frame_start_irq_o)
    else $error("frame irq missing");
  flush_done_a:
    assert property (fifo_flush_o |-> !rx_done_o ##1 !rx_done_o)
    else $error("done after flush");
  baud_out_a:
    assert property (wr && paddr == 12'h0D4 |=> baud_sel_o == wd_q[2:0]
      && baud_valid_o == wd_q[2]) else $error("baud out");
  level_out_a:
    assert property (wr && paddr == 12'h0DC |=>
      {decoder_min_level_o, phase_min_level_o} == wd_q[7:0])
    else $error("levels out");
  front_out_a:
    assert property (wr && paddr == 12'h0E0 |=> front_cfg_o.input_sel ==
      wd_q[5:4] && front_cfg_o.converter_mode == wd_q[6])
    else $error("front cfg out");
  coll_out_a:
    assert property (wr && paddr == 12'h0E0 |=> front_cfg_o.coll_level ==
      wd_q[1:0] && collision_detect_en_o == (wd_q[1:0] != 2'h3))
    else $error("collision out");
  cover property (frame_start_irq_o);
  cover property (fifo_flush_o);
  cover property (rx_done_o);
endmodule
bind crx_top crx_asserts u_crx_asserts (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .frame_start_i(frame_start_i),
  .frame_start_irq_o(frame_start_irq_o), .fifo_flush_o(fifo_flush_o),
  .rx_done_o(rx_done_o), .baud_sel_o(baud_sel_o),
  .baud_valid_o(baud_valid_o), .decoder_min_level_o(decoder_min_level_o),
  .phase_min_level_o(phase_min_level_o), .front_cfg_o(front_cfg_o),
  .collision_detect_en_o(collision_detect_en_o));
`default_nettype wire

/* File: testbench/crx_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crx_card_model
(
  // clock
  input  wire logic  clk_i,
  // receive events
  output logic       fs_o,
  output logic       sc_o,
  output logic       bv_o,
  output logic [7:0] bd_o,
  output logic       fe_o,
  output logic       lp_o,
  output logic       er_o,
  output logic       co_o
);
  initial
  begin
    {fs_o, sc_o, bv_o, fe_o, lp_o, er_o, co_o} = 7'h0;
    bd_o = 8'h3C;
  end
  task automatic set_subc(input logic v);
    @(posedge clk_i);
    sc_o <= v;
  endtask
  task automatic frame(input int n, input int bad, input bit coll,
                       input bit part);
    @(posedge clk_i);
    fs_o <= 1'b1;
    @(posedge clk_i);
    fs_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (3) @(posedge clk_i);
      bv_o <= 1'b1;
      bd_o <= 8'hA0 + 8'(i);
      lp_o <= part && i == n - 1;
      er_o <= !coll && i == bad;
      co_o <= coll && i == bad;
      @(posedge clk_i);
      bv_o <= 1'b0;
      // stale data never looks like a byte
      bd_o <= ~bd_o;
      {lp_o, er_o, co_o} <= 3'h0;
    end
    repeat (3) @(posedge clk_i);
    fe_o <= 1'b1;
    @(posedge clk_i);
    fe_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import crx_pkg::*;
  logic        clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fs, sc, bv, fe, lp, er, co, tx, ck, e, blank;
  logic [7:0]  bd, ereg, last_d;
  logic [4:0]  ev;
  crx_byte_t   fifo;
  int          error_cnt, cmp_count;
  int          cnt [5];
  int          base [5];
  string       nm [5] = '{"fifo", "flush", "done", "stop", "irq"};
  logic [31:0] rv [5] = '{RST_FSD, RST_RCT, RST_BLK, RST_THR, RST_RIS};
  logic [31:0] wm [5] = '{FSD_WMASK, RCT_WMASK, 8'hFF, 8'hFF, RIS_WMASK};
  assign ev[0] = fifo.valid;
  crx_top u_crx_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start_i(fs), .subcarrier_pin_i(sc), .byte_valid_i(bv),
    .byte_data_i(bd), .frame_end_i(fe), .last_partial_i(lp),
    .rx_error_i(er), .collision_i(co), .tx_done_i(tx), .checksum_en_i(ck),
    .error_reg_i(ereg), .fifo_o(fifo), .fifo_flush_o(ev[1]),
    .rx_done_o(ev[2]), .rx_stop_o(ev[3]), .frame_start_irq_o(ev[4]),
    .rx_blank_o(blank), .baud_sel_o(), .baud_valid_o(),
    .decoder_min_level_o(), .phase_min_level_o(), .front_cfg_o(),
    .collision_detect_en_o());
  crx_card_model u_crx_card_model (.clk_i(clk_i), .fs_o(fs), .sc_o(sc),
    .bv_o(bv), .bd_o(bd), .fe_o(fe), .lp_o(lp), .er_o(er), .co_o(co));
  always @(posedge clk_i)
    for (int k = 0; k < 5; k++)
      cnt[k] <= cnt[k] + int'(ev[k] === 1'b1);
  always @(posedge clk_i)
    if (fifo.valid === 1'b1)
      last_d <= fifo.data;
  task automatic chk(input string n, input logic [31:0] x, got);
    cmp_count++;
    if (got !== x)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, got);
    end
  endtask
  task automatic chkc(input int k, input int x);
    chk(nm[k], 32'(x), 32'(cnt[k] - base[k]));
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, rd);
  endtask
  task automatic tx_blank(input int hi, input int lo);
    tx <= 1'b1;
    @(posedge clk_i);
    tx <= 1'b0;
    repeat (hi) @(posedge clk_i);
    chk("blank on", 1, blank);
    repeat (lo) @(posedge clk_i);
    chk("blank off", 0, blank);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    #3000000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    {reset_n_i, psel, penable, pwrite, tx, ck} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ereg = 8'h00;
    cnt = '{default: 0};
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++)
      rdc(12'h0D0 + 12'(4 * i), rv[i]);
    rdc(12'h100, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 1, e);
    apb(1'b0, 12'h0D5, 32'h0);
    chk("slverr", 1, e);
    chk("err data", 0, rd);
    wr(12'h0D1, 32'hFF);
    chk("slverr", 1, e);
    rdc(12'h0D0, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(12'h0D0 + 12'(4 * i), 32'hFFFF_FFFF);
      rdc(12'h0D0 + 12'(4 * i), wm[i]);
    end
    for (int c = 0; c < 8; c++)
      wr(12'h0D4, 32'(c));
    for (int c = 0; c < 4; c++)
      wr(12'h0E0, 32'(c * 8'h11 + (c % 2) * 8'h40));
    wr(12'h0DC, 32'h5A);
    $display("test registers done");
    wr(12'h0D4, 32'h04);
    wr(12'h0D0, 32'h24);
    base = cnt;
    u_crx_card_model.frame(1, -1, 0, 0);
    chkc(4, 1);
    rdc(12'h0D0, 32'h34);
    wr(12'h0D0, 32'h34);
    rdc(12'h0D0, 32'h34);
    wr(12'h0D0, 32'h24);
    rdc(12'h0D0, 32'h24);
    base = cnt;
    u_crx_card_model.set_subc(1'b1);
    repeat (10) @(posedge clk_i);
    rdc(12'h0D0, 32'h27);
    chkc(4, 1);
    u_crx_card_model.set_subc(1'b0);
    repeat (10) @(posedge clk_i);
    rdc(12'h0D0, 32'h26);
    wr(12'h0D0, 32'h00);
    rdc(12'h0D0, 32'h00);
    base = cnt;
    u_crx_card_model.frame(1, -1, 0, 0);
    chkc(4, 0);
    $display("test detect done");
    ereg <= 8'h5C;
    wr(12'h0D4, 32'h44);
    base = cnt;
    u_crx_card_model.frame(2, -1, 0, 0);
    chkc(0, 3);
    chk("error byte", 32'h5C, last_d);
    chkc(3, 0);
    wr(12'h0D4, 32'h04);
    base = cnt;
    u_crx_card_model.frame(2, -1, 0, 0);
    chkc(3, 1);
    $display("test multi done");
    wr(12'h0D4, 32'h0C);
    wr(12'h0E0, 32'h10);
    for (int t = 0; t < 3; t++)
    begin
      base = cnt;
      u_crx_card_model.frame(3 - t / 2, 2 - 2 * t, t == 1, 0);
      chk("flush seen", 1, 32'(cnt[1] > base[1]));
      chkc(2, 0);
    end
    base = cnt;
    u_crx_card_model.frame(4, -1, 0, 0);
    chkc(1, 0);
    chkc(0, 4);
    chkc(2, 1);
    $display("test suppress done");
    ck <= 1'b1;
    wr(12'h0D4, 32'h84);
    base = cnt;
    u_crx_card_model.frame(1, -1, 0, 1);
    chkc(0, 1);
    wr(12'h0D4, 32'h04);
    wr(12'h0D8, 32'h03);
    tx_blank(20, 25);
    wr(12'h0D8, 32'h81);
    tx_blank(30, 30);
    wr(12'h0D4, 32'h07);
    tx_blank(3, 6);
    $display("test blank done");
    print_verdict();
  end
endmodule
`default_nettype wire
